//--- design/ssbl_band_loader.sv
/*
  Harmonic band loader: on a trigger, walks the six alarm bands and emits
  one start/stop pair per cycle, scaled from the base frequency.
  Assumes the alarm band store accepts one write per cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module ssbl_band_loader
    import ssbl_pkg::*;
#(
    parameter logic [15:0] MAX_FREQ_HZ = 16'hffff
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_trigger,
    input  wire logic [15:0] i_fund_hz,
    output logic             o_band_wr,
    output logic      [2:0]  o_band_idx,
    output logic      [15:0] o_band_start,
    output logic      [15:0] o_band_stop,
    output logic             o_busy
);

    // rounds down; saturates at the top of the band range
    function automatic logic [15:0] edge_hz(input logic [15:0] f,
                                            input logic [5:0]  k);
        logic [21:0] prod;
        logic [21:0] quot;
        prod = 22'(f) * 22'(k);
        quot = prod / 22'(EDGE_DIV);
        if (quot > {6'h00, MAX_FREQ_HZ})
            return MAX_FREQ_HZ;
        return quot[15:0];
    endfunction

    ssbl_band_t  state_q, state_d;
    logic [2:0]  idx_q, idx_d;
    logic [15:0] fund_q, fund_d;
    logic        wr_q, wr_d;
    logic [2:0]  oidx_q, oidx_d;
    logic [15:0] start_q, start_d;
    logic [15:0] stop_q, stop_d;

    always_comb
    begin
        state_d = state_q;
        idx_d   = idx_q;
        fund_d  = fund_q;
        wr_d    = 1'b0;
        oidx_d  = oidx_q;
        start_d = start_q;
        stop_d  = stop_q;
        case (state_q)
            BL_IDLE: ;
            BL_RUN:
            begin
                wr_d    = 1'b1;
                oidx_d  = idx_q;
                start_d = edge_hz(fund_q, EDGE_FIFTHS[idx_q]);
                stop_d  = (idx_q == BAND_LAST) ? MAX_FREQ_HZ
                        : edge_hz(fund_q, EDGE_FIFTHS[idx_q + 3'd1]);
                idx_d   = idx_q + 3'd1;
                if (idx_q == BAND_LAST)
                    state_d = BL_IDLE;
            end
            default: state_d = BL_IDLE;
        endcase
        // a new trigger restarts the walk with the newest frequency
        if (i_trigger)
        begin
            state_d = BL_RUN;
            idx_d   = 3'd0;
            fund_d  = i_fund_hz;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= BL_IDLE;
            idx_q   <= 3'd0;
            fund_q  <= FUND_RESET;
            wr_q    <= 1'b0;
            oidx_q  <= 3'd0;
            start_q <= 16'h0000;
            stop_q  <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            idx_q   <= idx_d;
            fund_q  <= fund_d;
            wr_q    <= wr_d;
            oidx_q  <= oidx_d;
            start_q <= start_d;
            stop_q  <= stop_d;
        end
    end

    assign o_band_wr    = wr_q;
    assign o_band_idx   = oidx_q;
    assign o_band_start = start_q;
    assign o_band_stop  = stop_q;
    assign o_busy       = (state_q == BL_RUN) || wr_q;

endmodule

`default_nettype wire

//--- design/ssbl_pin_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes the pins are quasi-static relative to the system clock; the
  second stage is the only reader of the first.
*/
`timescale 1ns/1ps
`default_nettype none

module ssbl_pin_sync #(
    parameter int           W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

`default_nettype wire

//--- design/ssbl_stat_select.sv
/*
  Statistic selector and harmonic band loader register block, reached
  over the serial port (mode 3, 16-bit frames, MSB first).
  Assumes the statistic engine supplies its results on the system clock,
  and that the serial clock runs at most at one eighth of the system clock
  with chip select high for at least four system clocks between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module ssbl_stat_select #(
    parameter logic [15:0] MAX_FREQ_HZ = 16'hffff
) (
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_nrst,
    // serial port pins
    input  wire logic                     i_sclk,
    input  wire logic                     i_cs_n,
    input  wire logic                     i_din,
    output logic                          o_dout,
    // statistic engine results, codes 0..3 as 16-bit acceleration codes
    input  wire logic [4*16-1:0]          i_x_accel_stats,
    input  wire logic [4*16-1:0]          i_y_accel_stats,
    input  wire logic [4*16-1:0]          i_z_accel_stats,
    // codes 4..6 as unsigned 16.8 values
    input  wire logic [3*24-1:0]          i_x_shape_stats,
    input  wire logic [3*24-1:0]          i_y_shape_stats,
    input  wire logic [3*24-1:0]          i_z_shape_stats,
    // state seen by the rest of the device
    output ssbl_pkg::ssbl_stat_t          o_selector,
    output logic                          o_fixed_point,
    output logic [15:0]                   o_fund_hz,
    // alarm band store
    output logic                          o_band_wr,
    output logic [2:0]                    o_band_idx,
    output logic [15:0]                   o_band_start,
    output logic [15:0]                   o_band_stop,
    output logic                          o_band_busy
);

    import ssbl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // shape statistics beyond 255.996 saturate rather than wrap
    function automatic logic [15:0] to_fixed88(input logic [23:0] v);
        if (v[23:16] != 8'h00)
            return 16'hffff;
        return v[15:0];
    endfunction

    function automatic logic [15:0] pick_result(
        input logic [2:0]                       sel,
        input logic [ACCEL_STATS*RESULT_W-1:0]  accel,
        input logic [SHAPE_STATS*SHAPE_W-1:0]   shape
    );
        logic [2:0] shape_idx;
        shape_idx = sel - 3'd4;
        if (sel <= STAT_PEAK2PEAK)
            return accel[sel*RESULT_W +: RESULT_W];
        if (sel <= STAT_SKEWNESS)
            return to_fixed88(shape[shape_idx*SHAPE_W +: SHAPE_W]);
        // unassigned code 7 reads as zero
        return 16'h0000;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and serial clock edges

    logic [2:0] pins_s;
    logic       sclk_s;
    logic       cs_n_s;
    logic       din_s;
    logic       sclk_prev_q;
    logic       sclk_rise;
    logic       sclk_fall;

    // sclk idles high in mode 3, chip select idles high
    ssbl_pin_sync #(
        .W         (3),
        .RESET_VAL (3'b110)
    ) u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_async   ({i_sclk, i_cs_n, i_din}),
        .o_sync    (pins_s)
    );

    assign sclk_s    = pins_s[2];
    assign cs_n_s    = pins_s[1];
    assign din_s     = pins_s[0];
    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            sclk_prev_q <= 1'b1;
        else
            sclk_prev_q <= sclk_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // frame decode

    ssbl_frame_t frame_q, frame_d;
    logic [3:0]  bit_cnt_q, bit_cnt_d;
    logic [15:0] rx_q, rx_d;
    logic [15:0] tx_q, tx_d;
    logic [15:0] read_q, read_d;
    logic        dout_q, dout_d;
    logic [15:0] rx_word;
    logic        word_done;
    logic        cmd_write;
    logic [6:0]  cmd_addr;
    logic [7:0]  cmd_data;

    assign rx_word   = {rx_q[14:0], din_s};
    assign word_done = (frame_q == FR_SHIFT) && !cs_n_s && sclk_rise
                    && (bit_cnt_q == BIT_CNT_LAST);
    assign cmd_write = rx_word[WR_FLAG_BIT];
    assign cmd_addr  = rx_word[14:8];
    assign cmd_data  = rx_word[7:0];

    ////////////////////////////////////////////////////////////////////////
    // register file and result selection

    logic [2:0]  sel_q, sel_d;
    logic [15:0] fund_q, fund_d;
    logic        trig_q, trig_d;
    logic [15:0] x_result;
    logic [15:0] y_result;
    logic [15:0] z_result;
    logic [15:0] read_word;

    assign x_result = pick_result(sel_q, i_x_accel_stats,
                                  i_x_shape_stats);
    assign y_result = pick_result(sel_q, i_y_accel_stats,
                                  i_y_shape_stats);
    assign z_result = pick_result(sel_q, i_z_accel_stats,
                                  i_z_shape_stats);

    always_comb
    begin
        case (cmd_addr & WORD_MASK)
            ADDR_SELECTOR: read_word = {13'h0000, sel_q};
            ADDR_X_RESULT: read_word = x_result;
            ADDR_Y_RESULT: read_word = y_result;
            ADDR_Z_RESULT: read_word = z_result;
            ADDR_FUND:     read_word = fund_q;
            default:       read_word = 16'h0000;
        endcase
    end

    always_comb
    begin
        sel_d  = sel_q;
        fund_d = fund_q;
        trig_d = 1'b0;
        if (word_done && cmd_write)
        begin
            case (cmd_addr)
                ADDR_SELECTOR: sel_d = cmd_data[2:0];
                ADDR_FUND:     fund_d[7:0] = cmd_data;
                ADDR_FUND_HI:
                begin
                    fund_d[15:8] = cmd_data;
                    // zero disables the feature entirely
                    trig_d = ({cmd_data, fund_q[7:0]} != 16'h0000);
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sel_q  <= SELECTOR_RESET;
            fund_q <= FUND_RESET;
            trig_q <= 1'b0;
        end
        else
        begin
            sel_q  <= sel_d;
            fund_q <= fund_d;
            trig_q <= trig_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial frame engine; a read is answered in the following frame

    always_comb
    begin
        frame_d   = frame_q;
        bit_cnt_d = bit_cnt_q;
        rx_d      = rx_q;
        tx_d      = tx_q;
        read_d    = read_q;
        dout_d    = dout_q;
        case (frame_q)
            FR_IDLE:
            begin
                if (!cs_n_s)
                begin
                    frame_d   = FR_SHIFT;
                    bit_cnt_d = BIT_CNT_RESET;
                    tx_d      = read_q;
                    dout_d    = read_q[15];
                end
            end
            FR_SHIFT:
            begin
                // chip select lost mid-frame drops the partial word
                if (cs_n_s)
                    frame_d = FR_IDLE;
                else
                begin
                    if (sclk_fall)
                    begin
                        dout_d = tx_q[15];
                        tx_d   = {tx_q[14:0], 1'b0};
                    end
                    if (sclk_rise)
                    begin
                        rx_d      = rx_word;
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                    if (word_done)
                    begin
                        frame_d = FR_HOLD;
                        read_d  = cmd_write ? READ_RESET : read_word;
                    end
                end
            end
            FR_HOLD:
            begin
                // extra clocks after sixteen bits are ignored
                if (cs_n_s)
                    frame_d = FR_IDLE;
            end
            default: frame_d = FR_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            frame_q   <= FR_IDLE;
            bit_cnt_q <= BIT_CNT_RESET;
            rx_q      <= 16'h0000;
            tx_q      <= 16'h0000;
            read_q    <= READ_RESET;
            dout_q    <= 1'b0;
        end
        else
        begin
            frame_q   <= frame_d;
            bit_cnt_q <= bit_cnt_d;
            rx_q      <= rx_d;
            tx_q      <= tx_d;
            read_q    <= read_d;
            dout_q    <= dout_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // harmonic band loading

    ssbl_band_loader #(
        .MAX_FREQ_HZ (MAX_FREQ_HZ)
    ) u_band_loader (
        .i_sys_clk    (i_sys_clk),
        .i_nrst       (i_nrst),
        .i_trigger    (trig_q),
        .i_fund_hz    (fund_q),
        .o_band_wr    (o_band_wr),
        .o_band_idx   (o_band_idx),
        .o_band_start (o_band_start),
        .o_band_stop  (o_band_stop),
        .o_busy       (o_band_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_dout        = dout_q;
    assign o_selector    = ssbl_stat_t'(sel_q);
    assign o_fixed_point = (sel_q >= STAT_CREST)
                        && (sel_q <= STAT_SKEWNESS);
    assign o_fund_hz     = fund_q;

endmodule

`default_nettype wire

//--- include/ssbl_pkg.sv
/*
  Shared constants and types for the statistic selector and band loader:
  serial frame layout, register byte addresses, reset values, statistic
  codes, result formats and the harmonic band edge table.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package ssbl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // serial frame: write flag, 7-bit byte address, data byte
    localparam int         FRAME_BITS    = 16;
    localparam int         WR_FLAG_BIT   = 15;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [3:0] BIT_CNT_LAST  = 4'hf;

    ////////////////////////////////////////////////////////////////////////
    // byte addresses; each register is a word at an even address
    localparam logic [6:0] ADDR_SELECTOR = 7'h72;
    localparam logic [6:0] ADDR_X_RESULT = 7'h74;
    localparam logic [6:0] ADDR_Y_RESULT = 7'h76;
    localparam logic [6:0] ADDR_Z_RESULT = 7'h78;
    localparam logic [6:0] ADDR_FUND     = 7'h7a;
    localparam logic [6:0] ADDR_FUND_HI  = 7'h7b;
    localparam logic [6:0] WORD_MASK     = 7'h7e;

    localparam logic [2:0]  SELECTOR_RESET = 3'h0;
    localparam logic [15:0] FUND_RESET     = 16'h0000;
    localparam logic [15:0] READ_RESET     = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // statistic codes and result formats
    typedef enum logic [2:0] {
        STAT_MEAN      = 3'b000,
        STAT_STDDEV    = 3'b001,
        STAT_PEAK      = 3'b010,
        STAT_PEAK2PEAK = 3'b011,
        STAT_CREST     = 3'b100,
        STAT_KURTOSIS  = 3'b101,
        STAT_SKEWNESS  = 3'b110
    } ssbl_stat_t;

    localparam int ACCEL_STATS = 4;
    localparam int SHAPE_STATS = 3;
    localparam int RESULT_W    = 16;
    localparam int SHAPE_W     = 24;
    localparam int FRAC_BITS   = 8;

    ////////////////////////////////////////////////////////////////////////
    // band edges in fifths of the base frequency: 0.2 0.8 1.8 2.8 3.8 10.2
    localparam int         BAND_COUNT = 6;
    localparam logic [2:0] BAND_LAST  = 3'd5;
    localparam int         EDGE_DIV   = 5;
    localparam logic [5:0] EDGE_FIFTHS [0:BAND_COUNT-1] =
        '{6'd1, 6'd4, 6'd9, 6'd14, 6'd19, 6'd51};

    typedef enum logic [1:0] {
        FR_IDLE  = 2'b00,
        FR_SHIFT = 2'b01,
        FR_HOLD  = 2'b10
    } ssbl_frame_t;

    typedef enum logic [0:0] {
        BL_IDLE = 1'b0,
        BL_RUN  = 1'b1
    } ssbl_band_t;

endpackage

`default_nettype wire

//--- verification/ssbl_host_model.sv
/*
  Host serial master: mode 3 frames of 16 bits, MSB first.
  Assumes a 50 MHz system clock; every half sclk period is five clocks,
  above the four-clock minimum the block needs to see each level.
*/
`timescale 1ns/1ps
`default_nettype none

module ssbl_host_model (
    input  wire logic i_sys_clk,
    input  wire logic i_dout,
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_din
);
    initial
    begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    // sends w, returns what the block shifted out (previous answer)
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        wait_clk(1);
        o_cs_n = 1'b0;
        wait_clk(5);
        for (int i = 15; i >= 0; i--)
        begin
            o_sclk = 1'b0;
            o_din  = w[i];
            wait_clk(5);
            o_sclk = 1'b1;
            r[i]   = i_dout;
            wait_clk(5);
        end
        o_cs_n = 1'b1;
        // released data line shows the inverse so stale bits never match
        o_din  = ~o_din;
        wait_clk(6);
    endtask
endmodule

`default_nettype wire

//--- verification/ssbl_stat_select_monitor.sv
/*
  Checker for the statistic selector top: result format flag and the
  harmonic band walk, watched at the top ports only.
  Assumes one clock domain and the top's MAX_FREQ_HZ handed in by bind.
*/
`timescale 1ns/1ps
`default_nettype none

module ssbl_stat_select_monitor
    import ssbl_pkg::*;
#(
    parameter logic [15:0] MAX_FREQ_HZ = 16'hffff
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  var  ssbl_stat_t  o_selector,
    input  wire logic        o_fixed_point,
    input  wire logic [15:0] o_fund_hz,
    input  wire logic        o_band_wr,
    input  wire logic [2:0]  o_band_idx,
    input  wire logic [15:0] o_band_start,
    input  wire logic [15:0] o_band_stop,
    input  wire logic        o_band_busy
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    // only called with indices 0..5
    function automatic logic [15:0] band_edge(logic [15:0] f, logic [2:0] i);
        logic [31:0] v;
        v = 32'(f) * 32'(EDGE_FIFTHS[i]) / 32'd5;
        return (v > 32'(MAX_FREQ_HZ)) ? MAX_FREQ_HZ : v[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    sequence s_walk_start;
        o_band_wr && o_band_idx == 3'd0;
    endsequence
    sequence s_six;
        o_band_wr [*6];
    endsequence

    property p_fixed;
        o_fixed_point == (o_selector inside {STAT_CREST, STAT_KURTOSIS,
            STAT_SKEWNESS});
    endproperty
    property p_walk;
        $rose(o_band_wr) |-> s_walk_start ##0 s_six ##1 !o_band_wr;
    endproperty
    // a changed upper byte can only come from an upper byte write
    property p_load;
        ($changed(o_fund_hz[15:8]) && o_fund_hz != 16'h0000)
            |-> ##[1:3] s_walk_start;
    endproperty
    property p_step;
        (o_band_wr && o_band_idx < BAND_LAST) |=> (o_band_wr
            && o_band_idx == $past(o_band_idx) + 3'd1
            && o_band_start == $past(o_band_stop));
    endproperty
    property p_start;
        o_band_wr |-> o_band_start == band_edge(o_fund_hz, o_band_idx);
    endproperty
    property p_stop;
        o_band_wr |-> o_band_stop == ((o_band_idx == BAND_LAST) ?
            MAX_FREQ_HZ : band_edge(o_fund_hz, o_band_idx + 3'd1));
    endproperty
    property p_zero;
        o_band_wr |-> o_fund_hz != 16'h0000;
    endproperty
    property p_busy;
        o_band_wr |-> o_band_busy && $past(o_band_busy);
    endproperty

    a_fixed: assert property (p_fixed)
        else $error("format flag disagrees with selector");
    a_walk: assert property (p_walk)
        else $error("band walk not six writes from index zero");
    a_load: assert property (p_load)
        else $error("upper byte write did not start band load");
    a_step: assert property (p_step)
        else $error("band index or edge chain broken");
    a_start: assert property (p_start)
        else $error("band start frequency wrong");
    a_stop: assert property (p_stop)
        else $error("band stop frequency wrong");
    a_zero: assert property (p_zero)
        else $error("band write with zero base frequency");
    a_busy: assert property (p_busy)
        else $error("band write while loader idle");
endmodule

bind ssbl_stat_select ssbl_stat_select_monitor #(
    .MAX_FREQ_HZ(MAX_FREQ_HZ)
) u_mon (
    .i_sys_clk    (i_sys_clk),
    .i_nrst       (i_nrst),
    .o_selector   (o_selector),
    .o_fixed_point(o_fixed_point),
    .o_fund_hz    (o_fund_hz),
    .o_band_wr    (o_band_wr),
    .o_band_idx   (o_band_idx),
    .o_band_start (o_band_start),
    .o_band_stop  (o_band_stop),
    .o_band_busy  (o_band_busy)
);

`default_nettype wire

//--- verification/ssbl_stat_select_tb.sv
/*
  Testbench for the statistic selector top: selector codes, result
  formats, base frequency and band loading, all through serial frames.
  Assumes the host model in its own file and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

module ssbl_stat_select_tb;
    import ssbl_pkg::*;

    localparam logic [15:0] MAX_HZ = 16'h2710;

    logic        i_sys_clk;
    logic        i_nrst;
    logic        sclk, cs_n, din, dout, fixed_pt, band_wr, band_busy;
    ssbl_stat_t  sel;
    logic [15:0] fund, band_start, band_stop;
    logic [2:0]  band_idx;
    logic [15:0] bs [6];
    logic [15:0] be [6];
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n_band = 0;
    logic [63:0] acc [3] = '{64'h4444_3333_2222_1111,
        64'h8004_7003_0002_fff1, 64'h5a5a_a5a5_00ff_8000};
    logic [71:0] shp [3] = '{{24'h001af2, 24'h00016a, 24'h0000ff},
        {24'h0100ff, 24'h00ffff, 24'h00020a},
        {24'h00069a, 24'h000001, 24'h000100}};

    ssbl_stat_select #(.MAX_FREQ_HZ(MAX_HZ)) uut (
        .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_din(din), .o_dout(dout),
        .i_x_accel_stats(acc[0]), .i_y_accel_stats(acc[1]),
        .i_z_accel_stats(acc[2]), .i_x_shape_stats(shp[0]),
        .i_y_shape_stats(shp[1]), .i_z_shape_stats(shp[2]),
        .o_selector(sel), .o_fixed_point(fixed_pt), .o_fund_hz(fund),
        .o_band_wr(band_wr), .o_band_idx(band_idx),
        .o_band_start(band_start), .o_band_stop(band_stop),
        .o_band_busy(band_busy)
    );

    ssbl_host_model u_host (
        .i_sys_clk(i_sys_clk), .i_dout(dout), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_din(din)
    );

    initial
    begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk)
        if (band_wr === 1'b1)
        begin
            bs[band_idx] = band_start;
            be[band_idx] = band_stop;
            n_band++;
        end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] r;
        u_host.xfer({1'b1, a, d}, r);
    endtask

    // the answer arrives in the frame after the request
    task automatic rd(input logic [6:0] a, output logic [15:0] r);
        u_host.xfer({1'b0, a, 8'h00}, r);
        u_host.xfer(16'h0000, r);
    endtask

    function automatic logic [15:0] res(int a, int c);
        logic [23:0] s;
        if (c < 4)
            return acc[a][c*16 +: 16];
        if (c == 7)
            return 16'h0000;
        s = shp[a][(c-4)*24 +: 24];
        return (s[23:16] != 8'h00) ? 16'hffff : s[15:0];
    endfunction

    function automatic logic [15:0] band_edge(logic [15:0] f, int i);
        logic [31:0] v;
        v = 32'(f) * 32'(EDGE_FIFTHS[i]) / 32'd5;
        return (v > 32'(MAX_HZ)) ? MAX_HZ : v[15:0];
    endfunction

    task automatic chk_bands(input logic [15:0] f, input int n0);
        chk(16'(n_band - n0), 16'h0006);
        for (int i = 0; i < 6; i++)
        begin
            chk(bs[i], band_edge(f, i));
            chk(be[i], (i == 5) ? MAX_HZ : band_edge(f, i + 1));
        end
    endtask

    task automatic final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge i_sys_clk);
        n_mismatch++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [15:0] r;
        int          n0;
        i_nrst = 1'b0;
        repeat (12) @(posedge i_sys_clk);
        #1 i_nrst = 1'b1;
        repeat (4) @(posedge i_sys_clk);
        rd(ADDR_SELECTOR, r);
        chk(r, 16'h0000);
        rd(ADDR_FUND, r);
        chk(r, 16'h0000);
        chk(16'(n_band), 16'h0000);
        $display("test reset done");
        // read-only place: this write must leave the x result alone
        wr(ADDR_X_RESULT, 8'hff);
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_SELECTOR, 8'hf8 | 8'(c));
            chk({13'h0, sel}, 16'(c));
            rd(ADDR_SELECTOR, r);
            chk(r, 16'(c));
            rd(ADDR_X_RESULT, r);
            chk(r, res(0, c));
            rd(ADDR_Y_RESULT, r);
            chk(r, res(1, c));
            rd(ADDR_Z_RESULT, r);
            chk(r, res(2, c));
        end
        $display("test selector done");
        n0 = n_band;
        wr(ADDR_FUND, 8'h64);
        chk(16'(n_band - n0), 16'h0000);
        wr(ADDR_FUND_HI, 8'h00);
        rd(ADDR_FUND, r);
        chk(r, 16'h0064);
        chk_bands(16'h0064, n0);
        n0 = n_band;
        wr(ADDR_FUND, 8'he8);
        wr(ADDR_FUND_HI, 8'h03);
        rd(ADDR_FUND, r);
        chk(r, 16'h03e8);
        chk_bands(16'h03e8, n0);
        $display("test band load done");
        n0 = n_band;
        wr(ADDR_FUND, 8'h00);
        wr(ADDR_FUND_HI, 8'h00);
        rd(ADDR_FUND, r);
        chk(r, 16'h0000);
        chk(fund, 16'h0000);
        chk(16'(n_band - n0), 16'h0000);
        rd(7'h7c, r);
        chk(r, 16'h0000);
        $display("test zero base done");
        final_report();
    end
endmodule

`default_nettype wire
